// file: cvs_cfg.svh
// Constants for the converter voltage-select register bank.
// Assumes inclusion by the bank modules and the bench only.
`ifndef CVS_CFG_SVH
`define CVS_CFG_SVH
`define CVS_ADDR_R4_SLEEP 8'h95
`define CVS_ADDR_R5_NORMAL 8'h96
`define CVS_ADDR_R5_SLEEP 8'h97
`define CVS_ADDR_R6_NORMAL 8'h98
`define CVS_CODE_MSB 7
`define CVS_CODE_LSB 1
`define CVS_DECAY_BIT 0
`define CVS_RST_R4_SLEEP 8'h28
`define CVS_RST_R5_NORMAL 8'h70
`define CVS_RST_R5_SLEEP 8'h70
`define CVS_RST_R6_NORMAL 8'hbe
`define CVS_STEP_FINE_MV 10
`define CVS_STEP_COARSE_MV 25
`define CVS_SLEW_STEP_NS 100
`define CVS_CLK_PERIOD_NS 10
`define CVS_SLEW_CYCLES ((`CVS_SLEW_STEP_NS + `CVS_CLK_PERIOD_NS - 1) / `CVS_CLK_PERIOD_NS)
`endif

// file: cvs_pkg.sv
// Types shared by the converter voltage-select register bank.
// Assumes the byte-wide register access of the target port.
package cvs_pkg;
   typedef struct packed {
      logic wr_en;
      logic rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cvs_req_t;
   typedef struct packed {
      logic [6:0] code;
      logic passive_decay;
   } cvs_rail_t;
   typedef enum logic [1:0] {
      CVS_HOLD,
      CVS_SLEW_DOWN,
      CVS_DECAY,
      CVS_RISE
   } cvs_ramp_t;
endpackage

// file: cvs_ramp.sv
// Per-rail target tracker: steps the active code toward the target, or jumps straight down to it in decay.
// Assumes target and select come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "cvs_cfg.svh"
module cvs_ramp
   import cvs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [6:0] target,
   input wire logic passive_decay,
   output logic [6:0] active_code,
   output logic drive_down,
   output logic busy
);
   localparam logic [7:0] STEP_CYC = 8'(`CVS_SLEW_CYCLES);
   cvs_ramp_t state_reg;
   cvs_ramp_t state_next;
   logic [6:0] code_reg;
   logic [7:0] tick_reg;
   wire tick_done = (tick_reg == STEP_CYC - 8'h01);
   wire lower = target < code_reg;
   wire higher = target > code_reg;
   always_comb begin
      case (state_reg)
         CVS_HOLD: begin
            if (lower && !passive_decay) begin
               state_next = CVS_SLEW_DOWN;
            end else if (lower) begin
               state_next = CVS_DECAY;
            end else if (higher) begin
               state_next = CVS_RISE;
            end else begin
               state_next = CVS_HOLD;
            end
         end
         // A change of direction or of the decay bit drops back to hold to decide again.
         CVS_SLEW_DOWN: begin
            state_next = (lower && !passive_decay) ? CVS_SLEW_DOWN : CVS_HOLD;
         end
         CVS_DECAY: begin
            state_next = CVS_HOLD;
         end
         CVS_RISE: begin
            state_next = higher ? CVS_RISE : CVS_HOLD;
         end
         default: state_next = CVS_HOLD;
      endcase
   end
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= CVS_HOLD;
         code_reg <= 7'h00;
         tick_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         tick_reg <= (state_reg == CVS_HOLD || tick_done) ? 8'h00 : tick_reg + 8'h01;
         if (state_reg == CVS_DECAY) begin
            code_reg <= target;
         end else if (state_reg != CVS_HOLD && tick_done) begin
            code_reg <= lower ? code_reg - 7'h01 : (higher ? code_reg + 7'h01 : code_reg);
         end
      end
   end
   assign active_code = code_reg;
   assign drive_down = (state_reg == CVS_SLEW_DOWN);
   assign busy = (state_reg != CVS_HOLD);
   a_decay_no_drive: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (state_reg == CVS_DECAY) |=> !drive_down && code_reg == $past(target))
      else $error("decay did not jump to target");
endmodule
`default_nettype wire

// file: cvs_regs.sv
// Voltage-select registers for rails four to six of the power manager.
// Assumes a byte access port decoded from the target serial interface.
`timescale 1ns/1ps
`default_nettype none
`include "cvs_cfg.svh"
module cvs_regs
   import cvs_pkg::*;
#(
   parameter logic [7:0] RST_R4_SLEEP = `CVS_RST_R4_SLEEP,
   parameter logic [7:0] RST_R5_NORMAL = `CVS_RST_R5_NORMAL,
   parameter logic [7:0] RST_R5_SLEEP = `CVS_RST_R5_SLEEP,
   parameter logic [7:0] RST_R6_NORMAL = `CVS_RST_R6_NORMAL,
   parameter logic [7:0] RST_R4_NORMAL = `CVS_RST_R4_SLEEP,
   parameter logic [7:0] RST_R6_SLEEP = `CVS_RST_R6_NORMAL
)
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire cvs_req_t req,
   output logic [7:0] rdata,
   output logic rvalid,
   input wire logic [2:0] sleep_enable,
   input wire logic [2:0] sleep_pin_n,
   input wire logic [2:0] coarse_range,
   input wire logic [6:0] rail4_normal_code_in,
   input wire logic [6:0] rail6_sleep_code_in,
   output logic [6:0] rail4_target_code,
   output logic [6:0] rail5_target_code,
   output logic [6:0] rail6_target_code,
   output logic [11:0] rail5_target_mv,
   output logic rail5_drive_down,
   output logic rail5_busy
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] pin_meta_reg;
   logic [2:0] pin_sync_reg;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pin_meta_reg <= 3'h7;
         pin_sync_reg <= 3'h7;
      end else begin
         pin_meta_reg <= sleep_pin_n;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   // Reset values are the factory image; the device variant picks them by parameter.
   logic [7:0] r4_sleep_reg;
   logic [7:0] r5_normal_reg;
   logic [7:0] r5_sleep_reg;
   logic [7:0] r6_normal_reg;
   wire hit_r4s = req.addr == `CVS_ADDR_R4_SLEEP;
   wire hit_r5n = req.addr == `CVS_ADDR_R5_NORMAL;
   wire hit_r5s = req.addr == `CVS_ADDR_R5_SLEEP;
   wire hit_r6n = req.addr == `CVS_ADDR_R6_NORMAL;
   // Sleep registers keep bit 0 at its factory value whatever is written.
   wire [7:0] wr_sleep4 = {req.wdata[7:1], RST_R4_SLEEP[0]};
   wire [7:0] wr_sleep5 = {req.wdata[7:1], RST_R5_SLEEP[0]};
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         r4_sleep_reg <= RST_R4_SLEEP;
         r5_normal_reg <= RST_R5_NORMAL;
         r5_sleep_reg <= RST_R5_SLEEP;
         r6_normal_reg <= RST_R6_NORMAL;
      end else if (req.wr_en) begin
         if (hit_r4s) begin
            r4_sleep_reg <= wr_sleep4;
         end
         if (hit_r5n) begin
            r5_normal_reg <= req.wdata;
         end
         if (hit_r5s) begin
            r5_sleep_reg <= wr_sleep5;
         end
         if (hit_r6n) begin
            r6_normal_reg <= req.wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   // Unmapped addresses in this bank read as zero.
   wire [7:0] rd_mux = hit_r4s ? r4_sleep_reg :
                       hit_r5n ? r5_normal_reg :
                       hit_r5s ? r5_sleep_reg :
                       hit_r6n ? r6_normal_reg : 8'h00;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 8'h00;
         rvalid <= 1'b0;
      end else begin
         rvalid <= req.rd_en;
         rdata <= req.rd_en ? rd_mux : rdata;
      end
   end

   // ----------------------------------------------------------------
   // Code selection
   // ----------------------------------------------------------------
   function automatic logic [6:0] code_of(input logic [7:0] r);
      code_of = r[`CVS_CODE_MSB:`CVS_CODE_LSB];
   endfunction
   function automatic logic [11:0] code_mv(input logic [6:0] c, input logic coarse);
      code_mv = coarse ? 12'(c * `CVS_STEP_COARSE_MV) : 12'(c * `CVS_STEP_FINE_MV);
   endfunction
   wire [2:0] use_sleep = sleep_enable & ~pin_sync_reg;
   wire [6:0] sel4 = use_sleep[0] ? code_of(r4_sleep_reg) : rail4_normal_code_in;
   wire [6:0] sel5 = use_sleep[1] ? code_of(r5_sleep_reg) : code_of(r5_normal_reg);
   wire [6:0] sel6 = use_sleep[2] ? rail6_sleep_code_in : code_of(r6_normal_reg);
   wire [6:0] r5_active;
   wire r5_down;
   wire r5_busy;
   cvs_ramp u_ramp5 (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .target(sel5),
      .passive_decay(r5_normal_reg[`CVS_DECAY_BIT]),
      .active_code(r5_active),
      .drive_down(r5_down),
      .busy(r5_busy)
   );
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rail4_target_code <= 7'h00;
         rail5_target_code <= 7'h00;
         rail6_target_code <= 7'h00;
         rail5_target_mv <= 12'h000;
         rail5_drive_down <= 1'b0;
         rail5_busy <= 1'b0;
      end else begin
         rail4_target_code <= sel4;
         rail5_target_code <= r5_active;
         rail6_target_code <= sel6;
         rail5_target_mv <= code_mv(r5_active, coarse_range[1]);
         rail5_drive_down <= r5_down;
         rail5_busy <= r5_busy;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_sleep_bit_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
      r4_sleep_reg[0] == RST_R4_SLEEP[0] && r5_sleep_reg[0] == RST_R5_SLEEP[0])
      else $error("sleep bit 0 changed");
   a_r5n_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
      req.wr_en && hit_r5n |=> r5_normal_reg == $past(req.wdata))
      else $error("rail5 normal write lost");
   a_r5s_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
      req.wr_en && hit_r5s |=> r5_sleep_reg[7:1] == $past(req.wdata[7:1]))
      else $error("rail5 sleep write lost");
   a_r6n_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
      req.wr_en && hit_r6n |=> r6_normal_reg == $past(req.wdata))
      else $error("rail6 normal write lost");
   a_r4s_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
      req.wr_en && hit_r4s |=> r4_sleep_reg[7:1] == $past(req.wdata[7:1]))
      else $error("rail4 sleep write lost");
   a_sleep_select: assert property (@(posedge clk_sys) disable iff (!arst_n)
      use_sleep[0] |=> rail4_target_code == $past(code_of(r4_sleep_reg)))
      else $error("rail4 sleep code not used");
   a_normal_select: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !use_sleep[1] && !r5_busy && sel5 == r5_active |=> rail5_target_code == $past(sel5))
      else $error("rail5 code not tracked");
   a_read_return: assert property (@(posedge clk_sys) disable iff (!arst_n)
      req.rd_en |=> rvalid && rdata == $past(rd_mux))
      else $error("read data wrong");
   a_active_slew: assert property (@(posedge clk_sys) disable iff (!arst_n)
      r5_down |-> !r5_normal_reg[`CVS_DECAY_BIT] || $past(r5_down))
      else $error("slew without decay clear");
endmodule
`default_nettype wire

// file: cvs_host.sv
// Host model for the voltage-select bank: issues byte reads and writes.
// Assumes the bench calls its tasks only after reset has been released.
`timescale 1ns/1ps
`default_nettype none
module cvs_host
   import cvs_pkg::*;
(
   input wire logic clk_sys,
   output cvs_req_t req,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   // ------------------------------------------------------------
   // Access port driver
   // ------------------------------------------------------------
   // Released address and data are inverted, so a stale value never matches by chance.
   initial begin
      req = '0;
   end
   // The answer stands for one cycle only, so it is taken at the falling edge after the request.
   task automatic drive(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic ok, output logic [7:0] q);
      @(negedge clk_sys);
      req = '{wr_en: w, rd_en: !w, addr: a, wdata: d};
      @(negedge clk_sys);
      ok = rvalid;
      q = rdata;
      req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
   endtask
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      logic ok;
      logic [7:0] q;
      drive(1'b1, a, d, ok, q);
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
      drive(1'b0, a, 8'h00, ok, d);
   endtask
endmodule
`default_nettype wire

// file: converter_voltage_select_regs_bench.sv
// Bench for the voltage-select bank: host accesses and rail outputs.
// Assumes the host model drives the access port at falling edges.
`timescale 1ns/1ps
`default_nettype none
`include "cvs_cfg.svh"
module converter_voltage_select_regs_bench;
   import cvs_pkg::*;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [2:0] sleep_enable = 3'h0;
   logic [2:0] sleep_pin_n = 3'h7;
   logic [2:0] coarse_range = 3'h0;
   logic [7:0] rdata;
   logic rvalid, dn, busy;
   logic [6:0] c4, c5, c6;
   logic [11:0] mv;
   cvs_req_t req;
   int num_errors = 0;
   int checked = 0;
   always #5 clk_sys = ~clk_sys;
   cvs_regs dut (.clk_sys(clk_sys), .arst_n(arst_n), .req(req), .rdata(rdata),
      .rvalid(rvalid), .sleep_enable(sleep_enable), .sleep_pin_n(sleep_pin_n),
      .coarse_range(coarse_range), .rail4_normal_code_in(7'h11),
      .rail6_sleep_code_in(7'h22), .rail4_target_code(c4), .rail5_target_code(c5),
      .rail6_target_code(c6), .rail5_target_mv(mv), .rail5_drive_down(dn),
      .rail5_busy(busy));
   cvs_host host (.clk_sys(clk_sys), .req(req), .rdata(rdata), .rvalid(rvalid));
   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk_out(input string n, input logic [11:0] e, input logic [11:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic ok;
      host.read_reg(a, d, ok);
      checked++;
      if (ok !== 1'b1 || d !== e) begin
         num_errors++;
         $display("wrong value read %h expected %h seen %h", a, e, d);
      end
   endtask
   // The ramp can take hundreds of cycles after reset, so the wait is generous but bounded.
   task automatic settle;
      int n;
      repeat (5) @(negedge clk_sys);
      for (n = 0; n < 2000 && busy !== 1'b0; n++) @(negedge clk_sys);
      chk_out("busy", 12'h0, {11'h0, busy});
      if (busy !== 1'b0) final_report();
   endtask
   task automatic sel(input logic [2:0] en, pin, cr, input logic [6:0] e4, e5, e6);
      @(negedge clk_sys);
      sleep_enable = en;
      sleep_pin_n = pin;
      coarse_range = cr;
      settle();
      chk_out("rail4", {5'h0, e4}, {5'h0, c4});
      chk_out("rail5", {5'h0, e5}, {5'h0, c5});
      chk_out("rail6", {5'h0, e6}, {5'h0, c6});
      chk_out("mv", e5 * (cr[1] ? 12'd25 : 12'd10), mv);
      $display("test select done");
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(negedge clk_sys);
      arst_n = 1'b1;
      chk_rd(`CVS_ADDR_R4_SLEEP, `CVS_RST_R4_SLEEP);
      chk_rd(`CVS_ADDR_R5_NORMAL, `CVS_RST_R5_NORMAL);
      chk_rd(`CVS_ADDR_R5_SLEEP, `CVS_RST_R5_SLEEP);
      chk_rd(`CVS_ADDR_R6_NORMAL, `CVS_RST_R6_NORMAL);
      chk_rd(8'h99, 8'h00);
      $display("test reset values done");
      for (int a = 8'h95; a <= 8'h99; a++) begin
         host.write_reg(8'(a), 8'hff);
         chk_rd(8'(a), (a == 8'h99) ? 8'h00 : (a[0] ? 8'hfe : 8'hff));
      end
      $display("test write readback done");
      host.write_reg(8'h95, 8'h2a);
      host.write_reg(8'h96, 8'h41);
      host.write_reg(8'h97, 8'h11);
      host.write_reg(8'h98, 8'h64);
      sel(3'h7, 3'h7, 3'h0, 7'h11, 7'h20, 7'h32);
      sel(3'h0, 3'h0, 3'h7, 7'h11, 7'h20, 7'h32);
      sel(3'h7, 3'h0, 3'h2, 7'h15, 7'h08, 7'h22);
      sel(3'h0, 3'h7, 3'h0, 7'h11, 7'h20, 7'h32);
      host.write_reg(8'h96, 8'h39);
      repeat (6) @(negedge clk_sys);
      chk_out("decay code", 12'h1c, {5'h0, c5});
      chk_out("decay drive", 12'h0, {11'h0, dn});
      host.write_reg(8'h96, 8'h34);
      repeat (6) @(negedge clk_sys);
      chk_out("slew drive", 12'h1, {11'h0, dn});
      chk_out("slew early", 12'h1, {11'h0, c5 != 7'h1a});
      settle();
      chk_out("slew code", 12'h1a, {5'h0, c5});
      chk_out("slew end", 12'h0, {11'h0, dn});
      $display("test ramp done");
      final_report();
   end
endmodule
`default_nettype wire
